// ==== rtl/dadc_pkg.sv ====
/*
 package for the dual converter output mux and per-channel power control.
 assumes one 10 MHz system clock and an apb master for the register file.
*/
package dadc_pkg;
   localparam int DADC_DW = 12;
   localparam int DADC_CLK_MHZ = 10;
   // nap recovery, in sample clock cycles
   localparam int DADC_NAP_RECOVERY_CYC = 100;
   // sleep recovery time in microseconds; reference recharge
   localparam int DADC_SLEEP_RECOVERY_US = 2000;
   localparam int DADC_SLEEP_RECOVERY_CYC = DADC_SLEEP_RECOVERY_US * DADC_CLK_MHZ;
   localparam logic [11:0] DADC_ADDR_CTRL = 12'h000;
   localparam logic [11:0] DADC_ADDR_STAT = 12'h004;
   localparam logic [11:0] DADC_ADDR_DATA = 12'h008;
   localparam int DADC_CTRL_SWAP = 0;
   localparam int DADC_CTRL_A_PD = 1;
   localparam int DADC_CTRL_A_OEN = 2;
   localparam int DADC_CTRL_B_PD = 3;
   localparam int DADC_CTRL_B_OEN = 4;
   // swap high, both channels sleeping with outputs off
   localparam logic [4:0] DADC_CTRL_RESET = 5'h1f;
   typedef enum logic [1:0] {DADC_RUN, DADC_NAP, DADC_SLEEP, DADC_WAKE} dadc_mode_e;
endpackage

// ==== rtl/dadc_chan.sv ====
/*
 one converter channel's mode logic and output stage.
 assumes the powerdown and output enable levels come from registers in the same clock domain.
*/
module dadc_chan
   import dadc_pkg::*;
#(
   parameter int SLEEP_CYC = DADC_SLEEP_RECOVERY_CYC
) (
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   input wire logic channel_powerdown_in,
   input wire logic output_enable_n_in,
   input wire logic sample_in,
   output logic active_out,
   output logic drive_out,
   output logic [1:0] mode_out
);
   dadc_mode_e mode, next_mode;
   logic [20:0] cnt, next_cnt;

   always_comb begin
      next_mode = mode;
      next_cnt = cnt;
      case (mode)
         DADC_RUN: begin
            if (channel_powerdown_in) begin
               next_mode = output_enable_n_in ? DADC_SLEEP : DADC_NAP; // [R8] [R9]
            end
         end
         DADC_NAP: begin
            if (output_enable_n_in && channel_powerdown_in) begin
               next_mode = DADC_SLEEP; // [R8]
            end else if (!channel_powerdown_in) begin
               next_mode = DADC_WAKE;
               next_cnt = 21'(DADC_NAP_RECOVERY_CYC); // [R9]
            end
         end
         DADC_SLEEP: begin
            if (channel_powerdown_in && !output_enable_n_in) begin
               next_mode = DADC_NAP;
            end else if (!channel_powerdown_in) begin
               next_mode = DADC_WAKE;
               next_cnt = 21'(SLEEP_CYC); // reference has to recharge first
            end
         end
         DADC_WAKE: begin
            if (channel_powerdown_in) begin
               next_mode = output_enable_n_in ? DADC_SLEEP : DADC_NAP;
            end else if (sample_in) begin
               // recovery counted in sample clocks
               if (cnt <= 21'h00_0001) begin
                  next_mode = DADC_RUN;
                  next_cnt = '0;
               end else begin
                  next_cnt = cnt - 21'h00_0001;
               end
            end
         end
         default: next_mode = DADC_SLEEP;
      endcase
   end

   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         mode <= DADC_SLEEP;
         cnt <= '0;
      end else begin
         mode <= next_mode;
         cnt <= next_cnt;
      end
   end

   assign active_out = (mode == DADC_RUN);
   // [R10] [R11] drive only when converting and enabled
   assign drive_out = (mode == DADC_RUN) && !output_enable_n_in;
   assign mode_out = mode;
endmodule

// ==== rtl/dadc_top.sv ====
/*
 dual channel output router with per-channel power and output control, apb slave.
 assumes the sample strobes are synchronous to clk_sys_in, one cycle per sample.
*/
// How it works
// [R1] each channel's power and output state come only from its own powerdown and enable bits.
// [R2] the two channels run separate mode machines so one converts while the other naps or sleeps.
// [R3] the outside system multiplexes onto one bus only at or below 80 Msps.
// [R4] with swap high channel a goes to the first bus and channel b to the second.
// [R5] with swap low the routing is exchanged.
// [R6] to interleave, the outside system ties swap and both sample clocks to one signal.
// [R7] interleaved data can be read on either bus and the unused bus can be disabled by its enable.
// [R8] powerdown high with enable off puts a channel to sleep.
// [R9] powerdown high with enable on puts a channel in nap, and it recovers in 100 sample clocks.
// [R10] with its enable off a channel's outputs and its overrange flag float.
// [R11] in nap or sleep all outputs of the channel float.
module dadc_top
   import dadc_pkg::*;
#(
   parameter int SLEEP_CYC = DADC_SLEEP_RECOVERY_CYC
) (
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic chan_a_sample_clock_in,
   input wire logic chan_b_sample_clock_in,
   input wire logic [DADC_DW-1:0] chan_a_sample_in,
   input wire logic [DADC_DW-1:0] chan_b_sample_in,
   input wire logic chan_a_overrange_in,
   input wire logic chan_b_overrange_in,
   input wire logic rx_ready_in,
   output logic rx_valid_out,
   output logic [DADC_DW-1:0] first_output_bus_out,
   output logic first_output_bus_oe_out,
   output logic [DADC_DW-1:0] second_output_bus_out,
   output logic second_output_bus_oe_out,
   output logic overrange_flag_out,
   output logic overrange_flag_oe_out
);
   logic [4:0] ctrl, next_ctrl;
   logic [31:0] next_prdata;
   logic next_pready, next_pslverr;
   logic a_act, b_act, a_drv, b_drv;
   logic [1:0] a_mode, b_mode;
   logic [DADC_DW-1:0] next_first, next_second;
   logic next_first_oe, next_second_oe, next_of, next_of_oe;
   // two-entry buffer of routed sample pairs {of, first, second}
   logic [2*DADC_DW:0] buf_mem [0:1];
   logic [2*DADC_DW:0] next_mem0, next_mem1;
   logic [1:0] cnt, next_cnt;
   logic rd_ptr, next_rd_ptr, wr_ptr, next_wr_ptr;
   logic in_valid, in_ready, pop;
   logic [2*DADC_DW:0] in_word;
   logic overflow, next_overflow;

   dadc_chan #(.SLEEP_CYC(SLEEP_CYC)) u_chan_a (
      .clk_sys_in(clk_sys_in),
      .resetn_in(resetn_in),
      .channel_powerdown_in(ctrl[DADC_CTRL_A_PD]), // [R1]
      .output_enable_n_in(ctrl[DADC_CTRL_A_OEN]),
      .sample_in(chan_a_sample_clock_in),
      .active_out(a_act),
      .drive_out(a_drv),
      .mode_out(a_mode)
   );
   dadc_chan #(.SLEEP_CYC(SLEEP_CYC)) u_chan_b (
      .clk_sys_in(clk_sys_in),
      .resetn_in(resetn_in),
      .channel_powerdown_in(ctrl[DADC_CTRL_B_PD]), // [R1] [R2]
      .output_enable_n_in(ctrl[DADC_CTRL_B_OEN]),
      .sample_in(chan_b_sample_clock_in),
      .active_out(b_act),
      .drive_out(b_drv),
      .mode_out(b_mode)
   );

   function automatic logic bus_sel_a(input logic swap, input logic first);
      // first bus carries a when swap high, second bus carries a when swap low
      return first ? swap : !swap;
   endfunction

   // routing of one sample pair into the buffer
   always_comb begin
      logic sw;
      logic fa, sa;
      sw = ctrl[DADC_CTRL_SWAP];
      fa = bus_sel_a(sw, 1'b1); // [R4] [R5]
      sa = bus_sel_a(sw, 1'b0);
      // a channel not converting adds no strobe, though its sample still fills its bus half of the word; the other keeps going
      // overrange is taken only from channel a, and only while it converts
      in_valid = (chan_a_sample_clock_in && a_act) || (chan_b_sample_clock_in && b_act); // [R2]
      in_word = {chan_a_overrange_in && a_act,
                 fa ? chan_a_sample_in : chan_b_sample_in,
                 sa ? chan_a_sample_in : chan_b_sample_in};
   end

   // samples cannot be held back at the source, so a word arriving on a full buffer is dropped and flagged
   assign in_ready = (cnt != 2'd2);
   // the downstream may stall; words held until it takes them
   assign pop = rx_valid_out && rx_ready_in;

   always_comb begin
      next_mem0 = buf_mem[0];
      next_mem1 = buf_mem[1];
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_cnt = cnt;
      next_overflow = overflow;
      if (in_valid && in_ready) begin
         if (wr_ptr) begin
            next_mem1 = in_word;
         end else begin
            next_mem0 = in_word;
         end
         next_wr_ptr = !wr_ptr;
      end
      if (in_valid && !in_ready) begin
         next_overflow = 1'b1;
      end
      if (pop) begin
         next_rd_ptr = !rd_ptr;
      end
      next_cnt = cnt + 2'((in_valid && in_ready) ? 1 : 0) - 2'(pop ? 1 : 0);
   end

   // output stage: bus enables follow each channel's drive state
   // head word comes from the next buffer state so the buses load on the same edge as rx_valid_out
   always_comb begin
      logic [2*DADC_DW:0] w;
      logic sw;
      w = '0;
      sw = ctrl[DADC_CTRL_SWAP];
      if (next_cnt != 2'd0) begin
         w = next_rd_ptr ? next_mem1 : next_mem0;
      end
      next_first = w[2*DADC_DW-1:DADC_DW];
      next_second = w[DADC_DW-1:0];
      // [R4] [R5] [R10] [R11] a bus floats when the channel routed to it is off
      next_first_oe = bus_sel_a(sw, 1'b1) ? a_drv : b_drv;
      next_second_oe = bus_sel_a(sw, 1'b0) ? a_drv : b_drv; // [R7]
      next_of = w[2*DADC_DW];
      // overrange follows channel a's state
      next_of_oe = a_drv; // [R10] [R11]
   end

   // apb: one wait-free access phase
   // a write lands at the setup edge; the access phase only carries the answer
   always_comb begin
      next_ctrl = ctrl;
      next_prdata = prdata;
      next_pready = 1'b0;
      next_pslverr = 1'b0;
      if (psel && !penable) begin
         next_pready = 1'b1;
         next_prdata = '0;
         case (paddr)
            DADC_ADDR_CTRL: begin
               if (pwrite) begin
                  next_ctrl = pwdata[4:0];
               end else begin
                  next_prdata = {27'h000_0000, ctrl};
               end
            end
            DADC_ADDR_STAT: begin
               next_prdata = {25'h000_0000, overflow, cnt, b_mode, a_mode};
            end
            DADC_ADDR_DATA: begin
               next_prdata = {7'h00, buf_mem[rd_ptr]};
            end
            default: next_pslverr = 1'b1;
         endcase
      end
   end

   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ctrl <= DADC_CTRL_RESET;
         prdata <= '0;
         pready <= 1'b0;
         pslverr <= 1'b0;
         buf_mem[0] <= '0;
         buf_mem[1] <= '0;
         cnt <= '0;
         rd_ptr <= 1'b0;
         wr_ptr <= 1'b0;
         overflow <= 1'b0;
         rx_valid_out <= 1'b0;
         first_output_bus_out <= '0;
         second_output_bus_out <= '0;
         first_output_bus_oe_out <= 1'b0;
         second_output_bus_oe_out <= 1'b0;
         overrange_flag_out <= 1'b0;
         overrange_flag_oe_out <= 1'b0;
      end else begin
         ctrl <= next_ctrl;
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
         buf_mem[0] <= next_mem0;
         buf_mem[1] <= next_mem1;
         cnt <= next_cnt;
         rd_ptr <= next_rd_ptr;
         wr_ptr <= next_wr_ptr;
         overflow <= next_overflow;
         rx_valid_out <= (next_cnt != 2'd0);
         first_output_bus_out <= next_first;
         second_output_bus_out <= next_second;
         first_output_bus_oe_out <= next_first_oe;
         second_output_bus_oe_out <= next_second_oe;
         overrange_flag_out <= next_of;
         overrange_flag_oe_out <= next_of_oe;
      end
   end
endmodule

// ==== bench/dadc_checker.sv ====
/*
 port checker for dadc_top: output enables against a shadow of the control word.
 assumes zero wait state apb writes to the control word, bound at the foot.
*/
module dadc_checker
   import dadc_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic first_output_bus_oe_out,
   input wire logic second_output_bus_oe_out,
   input wire logic overrange_flag_oe_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [4:0] sh, p1, p2, p3;
   logic st;
   // enables are registered behind the mode logic, so only judge a word held four edges
   assign st = (sh == p1) && (p1 == p2) && (p2 == p3);
   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         sh <= DADC_CTRL_RESET;
         p1 <= DADC_CTRL_RESET;
         p2 <= DADC_CTRL_RESET;
         p3 <= DADC_CTRL_RESET;
      end else begin
         if (psel && !penable && pwrite && paddr == DADC_ADDR_CTRL) begin
            sh <= pwdata[4:0];
         end
         p1 <= sh;
         p2 <= p1;
         p3 <= p2;
      end
   end
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!resetn_in);
   property p_a_down_first; st && sh[0] && sh[1] |-> !first_output_bus_oe_out; endproperty
   a_a_down_first: assert property (p_a_down_first) else $error("first bus driven by powered down a");
   property p_a_down_second; st && !sh[0] && sh[1] |-> !second_output_bus_oe_out; endproperty
   a_a_down_second: assert property (p_a_down_second) else $error("second bus driven by powered down a");
   property p_b_off_second; st && sh[0] && sh[4] |-> !second_output_bus_oe_out; endproperty
   a_b_off_second: assert property (p_b_off_second) else $error("second bus driven with b disabled");
   property p_b_off_first; st && !sh[0] && sh[4] |-> !first_output_bus_oe_out; endproperty
   a_b_off_first: assert property (p_b_off_first) else $error("first bus driven with b disabled");
   property p_of_off; st && (sh[1] || sh[2]) |-> !overrange_flag_oe_out; endproperty
   a_of_off: assert property (p_of_off) else $error("overrange driven with a off");
   property p_b_down; st && sh[3] |-> !(sh[0] ? second_output_bus_oe_out : first_output_bus_oe_out); endproperty
   a_b_down: assert property (p_b_down) else $error("bus driven by powered down b");
   property p_ready; psel && !penable |=> pready ##1 !pready; endproperty
   a_ready: assert property (p_ready) else $error("apb answer not one cycle after setup");
   property p_err; pslverr |-> pready; endproperty
   a_err: assert property (p_err) else $error("error without ready");
   c_swap_lo: cover property (st && !sh[0] && first_output_bus_oe_out);
   c_swap_hi: cover property (st && sh[0] && first_output_bus_oe_out);
   c_err: cover property (pslverr);
endmodule
bind dadc_top dadc_checker u_chk (.clk_sys_in, .resetn_in, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
   .pslverr, .first_output_bus_oe_out, .second_output_bus_oe_out, .overrange_flag_oe_out);

// ==== bench/dadc_sink.sv ====
/*
 downstream receiver model: counts each taken word, may stall.
 assumes the bench steers stalls from its own clocked process.
*/
module dadc_sink (
   input wire logic clk_sys_in,
   input wire logic stall_in,
   input wire logic rx_valid_in,
   output logic rx_ready_out,
   output int taken_out
);
   timeunit 1ns;
   timeprecision 1ns;
   initial taken_out = 0;
   // ready is the inverse of the stall input; words are only counted, no bus is read
   assign rx_ready_out = !stall_in;
   always @(posedge clk_sys_in) begin
      if (rx_valid_in && rx_ready_out) begin
         taken_out <= taken_out + 1;
      end
   end
endmodule

// ==== bench/dadc_top_bench.sv ====
/*
 bench for dadc_top: apb tasks, sample strobes, sink stalls.
 assumes a short sleep recovery parameter and zero wait state apb.
*/
module dadc_top_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import dadc_pkg::*;
   logic clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, rdy, vld, pre, err, fo, so, of, ofo, ca = 0, cb = 0;
   logic oa = 0, ob = 0, stall = 0;
   logic [11:0] pa = 12'h000, da = 12'h000, db = 12'h000, fb, sb;
   logic [31:0] pwd = 32'h0000_0000, prd, rd;
   int n_errors = 0, check_count = 0, taken;
   dadc_top #(.SLEEP_CYC(5)) u_dut (.clk_sys_in(clk), .resetn_in(rstn), .psel(psel), .penable(pen), .pwrite(pwr),
      .paddr(pa), .pwdata(pwd), .prdata(prd), .pready(pre), .pslverr(err), .chan_a_sample_clock_in(ca),
      .chan_b_sample_clock_in(cb), .chan_a_sample_in(da), .chan_b_sample_in(db), .chan_a_overrange_in(oa),
      .chan_b_overrange_in(ob), .rx_ready_in(rdy), .rx_valid_out(vld), .first_output_bus_out(fb),
      .first_output_bus_oe_out(fo), .second_output_bus_out(sb), .second_output_bus_oe_out(so),
      .overrange_flag_out(of), .overrange_flag_oe_out(ofo));
   dadc_sink u_sink (.clk_sys_in(clk), .stall_in(stall), .rx_valid_in(vld), .rx_ready_out(rdy), .taken_out(taken));
   initial forever #50 clk = ~clk;
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic summarize;
      $display("checks=%0d mismatches=%0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk) {psel, pen, pwr, pa, pwd} <= {2'b10, w, a, d};
      @(posedge clk) pen <= 1;
      n = 0;
      do begin
         @(posedge clk) n++;
      end while (pre !== 1'b1 && n < 20);
      rd = prd;
      {psel, pen} <= 2'b00;
      if (n >= 20) begin
         n_errors++;
         summarize();
      end
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input logic e_err);
      xfer(0, a, 0);
      check(rd, e);
      check({31'h0, err}, {31'h0, e_err});
   endtask
   // one strobe per selected channel every other cycle, far below the single-bus rate limit
   // outputs load at the take edge and are looked at 1 ns later
   task automatic strobe(input logic sa, input logic sb2, input logic [11:0] va, input logic [11:0] vb, input int k);
      repeat (k) begin
         @(posedge clk) {ca, cb, da, db} <= {sa, sb2, va, vb};
         @(posedge clk) {ca, cb} <= 2'b00;
      end
      #1;
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rstn <= 1;
      rdchk(DADC_ADDR_CTRL, 32'h0000_001f, 0);
      rdchk(DADC_ADDR_STAT, 32'h0000_000a, 0);
      rdchk(12'h0ff, 32'h0000_0000, 1);
      $display("test reset done");
      xfer(1, DADC_ADDR_CTRL, 32'h0000_0003);
      rdchk(DADC_ADDR_STAT, 32'h0000_000d, 0);
      strobe(0, 1, 12'h000, 12'h000, 5);
      rdchk(DADC_ADDR_STAT, 32'h0000_0001, 0);
      strobe(1, 1, 12'h0aa, 12'h5c3, 1);
      check({fo, so, sb}, {2'b01, 12'h5c3});
      $display("test nap done");
      xfer(1, DADC_ADDR_CTRL, 32'h0000_0001);
      strobe(1, 0, 12'h000, 12'h000, 99);
      rdchk(DADC_ADDR_STAT, 32'h0000_0003, 0);
      strobe(1, 0, 12'h000, 12'h000, 1);
      rdchk(DADC_ADDR_STAT, 32'h0000_0000, 0);
      oa <= 1;
      strobe(1, 1, 12'h123, 12'h456, 1);
      check({fo, so, fb, sb, ofo, of}, {2'b11, 24'h123_456, 2'b11});
      xfer(1, DADC_ADDR_CTRL, 32'h0000_0000);
      oa <= 0;
      strobe(1, 1, 12'h9e1, 12'h07f, 1);
      check({fo, so, fb, sb, of}, {2'b11, 24'h07f_9e1, 1'b0});
      $display("test routing done");
      xfer(1, DADC_ADDR_CTRL, 32'h0000_0018);
      stall <= 1;
      strobe(1, 1, 12'h321, 12'h654, 3);
      check({fo, so, sb}, {2'b01, 12'h321});
      rdchk(DADC_ADDR_STAT, 32'h0000_0068, 0);
      rdchk(DADC_ADDR_DATA, 32'h0065_4321, 0);
      stall <= 0;
      repeat (4) @(posedge clk);
      #1 check({31'h0, vld}, 32'h0000_0000);
      check(taken, 32'h0000_0005);
      $display("test sleep and stall done");
      summarize();
   end
endmodule
